//--- verilog/cepw_top.sv
// four 32-bit counters for edge counting and pulse-width measurement
`timescale 1ns/1ns
module cepw_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire cepw_pkg::cepw_cfg_t [cepw_pkg::NUM_CTR-1:0] cfg,
  input wire logic [cepw_pkg::NUM_CTR-1:0][cepw_pkg::NUM_IN-1:0] sig_in,
  input wire logic [cepw_pkg::NUM_CTR-1:0] arm,
  input wire logic [cepw_pkg::NUM_CTR-1:0] disarm,
  input wire logic [cepw_pkg::NUM_CTR-1:0] dma_ready,
  output logic [cepw_pkg::NUM_CTR-1:0] dma_valid,
  output logic [cepw_pkg::NUM_CTR-1:0][cepw_pkg::CNT_W-1:0] dma_data,
  output logic [cepw_pkg::NUM_CTR-1:0][cepw_pkg::CNT_W-1:0] count,
  output cepw_pkg::cepw_status_t [cepw_pkg::NUM_CTR-1:0] status
);

  typedef struct packed {
    cepw_pkg::cepw_ctr_t [cepw_pkg::NUM_CTR-1:0] ctr;
  } cepw_state_t;

  cepw_state_t s;
  cepw_state_t next_s;
  logic [cepw_pkg::NUM_CTR-1:0] fifo_in_ready;
  logic [cepw_pkg::NUM_CTR-1:0] fifo_out_valid;

  // picks one of the eight synchronised lines
  function automatic logic cepw_pick(
    input logic [cepw_pkg::NUM_IN-1:0] lines,
    input logic [cepw_pkg::SEL_W-1:0] sel
  );
    cepw_pick = lines[sel];
  endfunction : cepw_pick

  // edge of the chosen polarity between last and current sample
  function automatic logic cepw_edge(
    input logic now_lvl,
    input logic old_lvl,
    input logic rise
  );
    cepw_edge = rise ? (now_lvl && !old_lvl) : (!now_lvl && old_lvl);
  endfunction : cepw_edge

  always_comb begin
    logic src_lvl;
    logic src_old;
    logic gate_lvl;
    logic gate_old;
    logic samp_lvl;
    logic samp_old;
    logic dir_lvl;
    logic src_edge;
    logic samp_edge;
    logic gate_act;
    logic gate_was_act;
    logic paused;
    logic count_up;
    logic timed;
    logic illegal;
    logic want_push;
    logic [cepw_pkg::CNT_W-1:0] push_val;
    src_lvl = 1'b0;
    src_old = 1'b0;
    gate_lvl = 1'b0;
    gate_old = 1'b0;
    samp_lvl = 1'b0;
    samp_old = 1'b0;
    dir_lvl = 1'b0;
    src_edge = 1'b0;
    samp_edge = 1'b0;
    gate_act = 1'b0;
    gate_was_act = 1'b0;
    paused = 1'b0;
    count_up = 1'b0;
    timed = 1'b0;
    illegal = 1'b0;
    want_push = 1'b0;
    push_val = cepw_pkg::CNT_INIT;
    next_s = s;
    for (int i = 0; i < cepw_pkg::NUM_CTR; i++) begin
      // pins pass two flops; prev holds the older synchronised level
      next_s.ctr[i].sync1 = sig_in[i];
      next_s.ctr[i].sync2 = s.ctr[i].sync1;
      next_s.ctr[i].prev = s.ctr[i].sync2;
      next_s.ctr[i].push = 1'b0;

      src_lvl = cepw_pick(s.ctr[i].sync2, cfg[i].src_sel);
      src_old = cepw_pick(s.ctr[i].prev, cfg[i].src_sel);
      gate_lvl = cepw_pick(s.ctr[i].sync2, cfg[i].gate_sel);
      gate_old = cepw_pick(s.ctr[i].prev, cfg[i].gate_sel);
      samp_lvl = cepw_pick(s.ctr[i].sync2, cfg[i].samp_sel);
      samp_old = cepw_pick(s.ctr[i].prev, cfg[i].samp_sel);
      dir_lvl = cepw_pick(s.ctr[i].sync2, cfg[i].dir_sel);

      src_edge = cepw_edge(src_lvl, src_old, cfg[i].src_rise);
      samp_edge = cepw_edge(samp_lvl, samp_old, cfg[i].samp_rise);
      gate_act = (gate_lvl == cfg[i].gate_high);
      gate_was_act = (gate_old == cfg[i].gate_high);
      paused = cfg[i].pause_en && gate_act;

      // single-point work is always sample clocked
      timed = cfg[i].sampled || cfg[i].single_point;
      // buffered edge count has no implicit form
      illegal = (cfg[i].mode == cepw_pkg::MODE_EDGE) && cfg[i].buffered
        && !timed;

      case (cfg[i].dir_mode)
        cepw_pkg::DIR_UP: count_up = 1'b1;
        cepw_pkg::DIR_DOWN: count_up = 1'b0;
        cepw_pkg::DIR_EXT: count_up = dir_lvl;
        default: count_up = 1'b1;
      endcase

      want_push = 1'b0;
      push_val = s.ctr[i].cnt;

      case (s.ctr[i].st)
        cepw_pkg::ST_IDLE: begin
        end
        cepw_pkg::ST_WAIT_IDLE: begin
          if (!gate_act) begin
            next_s.ctr[i].st = cepw_pkg::ST_WAIT_ACT;
          end
        end
        cepw_pkg::ST_WAIT_ACT: begin
          if (gate_act && !gate_was_act) begin
            next_s.ctr[i].st = cepw_pkg::ST_MEAS;
            next_s.ctr[i].cnt = cepw_pkg::CNT_INIT;
          end
        end
        cepw_pkg::ST_MEAS: begin
          if (cfg[i].mode == cepw_pkg::MODE_EDGE) begin
            if (src_edge && !paused) begin
              // plain add and subtract wrap at 32 bits
              next_s.ctr[i].cnt = count_up
                ? s.ctr[i].cnt + cepw_pkg::CNT_STEP
                : s.ctr[i].cnt - cepw_pkg::CNT_STEP;
            end
            if (cfg[i].buffered && samp_edge) begin
              // running count is captured, never cleared
              want_push = 1'b1;
            end
          end else if (!gate_act) begin
            // trailing gate edge closes the pulse
            if (timed) begin
              next_s.ctr[i].aux_last = s.ctr[i].cnt;
              next_s.ctr[i].aux_done = 1'b1;
              next_s.ctr[i].st = cepw_pkg::ST_WAIT_ACT;
            end else if (cfg[i].buffered) begin
              want_push = 1'b1;
              next_s.ctr[i].st = cepw_pkg::ST_WAIT_ACT;
            end else begin
              want_push = 1'b1;
              next_s.ctr[i].st = cepw_pkg::ST_HOLD;
            end
          end else if (src_edge) begin
            next_s.ctr[i].cnt = s.ctr[i].cnt + cepw_pkg::CNT_STEP;
          end
        end
        cepw_pkg::ST_HOLD: begin
          // gate and source are ignored until the stored value is read
          if (dma_ready[i] && fifo_out_valid[i]) begin
            next_s.ctr[i].st = cepw_pkg::ST_IDLE;
          end
        end
        default: next_s.ctr[i].st = cepw_pkg::ST_IDLE;
      endcase

      // sample-clocked pulse width: report the last completed pulse
      if (cfg[i].mode == cepw_pkg::MODE_PWIDTH && timed && samp_edge
          && s.ctr[i].st != cepw_pkg::ST_IDLE
          && s.ctr[i].st != cepw_pkg::ST_HOLD) begin
        if (s.ctr[i].aux_done) begin
          want_push = 1'b1;
          push_val = s.ctr[i].aux_last;
          next_s.ctr[i].aux_done = (s.ctr[i].st == cepw_pkg::ST_MEAS) && !gate_act;
        end else begin
          next_s.ctr[i].status.overrun = 1'b1;
        end
      end

      // a full fifo drops the sample and leaves a sticky flag
      if (want_push) begin
        if (fifo_in_ready[i]) begin
          next_s.ctr[i].push = 1'b1;
          next_s.ctr[i].push_data = push_val;
        end else begin
          next_s.ctr[i].status.overflow = 1'b1;
        end
      end

      if (disarm[i]) begin
        next_s.ctr[i].st = cepw_pkg::ST_IDLE;
      end else if (arm[i]) begin
        next_s.ctr[i].cnt = cepw_pkg::CNT_INIT;
        next_s.ctr[i].aux_done = 1'b0;
        next_s.ctr[i].status.overrun = 1'b0;
        next_s.ctr[i].status.overflow = 1'b0;
        next_s.ctr[i].status.cfg_err = illegal;
        if (illegal) begin
          next_s.ctr[i].st = cepw_pkg::ST_IDLE;
        end else if (cfg[i].mode == cepw_pkg::MODE_EDGE) begin
          next_s.ctr[i].st = cepw_pkg::ST_MEAS;
        end else if (gate_act) begin
          next_s.ctr[i].st = cepw_pkg::ST_WAIT_IDLE;
        end else begin
          next_s.ctr[i].st = cepw_pkg::ST_WAIT_ACT;
        end
      end

      next_s.ctr[i].status.armed = (next_s.ctr[i].st != cepw_pkg::ST_IDLE);
      next_s.ctr[i].status.holding = (next_s.ctr[i].st == cepw_pkg::ST_HOLD);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < cepw_pkg::NUM_CTR; i++) begin
        s.ctr[i] <= '0;
        s.ctr[i].st <= cepw_pkg::ST_IDLE;
      end
    end else begin
      s <= next_s;
    end
  end

  genvar g;
  generate
    for (g = 0; g < cepw_pkg::NUM_CTR; g++) begin : g_ctr
      // reading the count is a plain flop tap and never disturbs it
      assign count[g] = s.ctr[g].cnt;
      assign status[g] = s.ctr[g].status;
      assign dma_valid[g] = fifo_out_valid[g];

      cepw_fifo #(
        .WIDTH(cepw_pkg::CNT_W),
        .DEPTH(cepw_pkg::FIFO_DEPTH),
        .PTR_W(cepw_pkg::FIFO_PTR_W)
      ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(s.ctr[g].push),
        .in_ready(fifo_in_ready[g]),
        .in_data(s.ctr[g].push_data),
        .out_valid(fifo_out_valid[g]),
        .out_ready(dma_ready[g]),
        .out_data(dma_data[g])
      );
    end
  endgenerate

endmodule : cepw_top

//--- verilog/cepw_pkg.sv
// shared constants and types for the counter edge / pulse-width input block
package cepw_pkg;

  localparam int NUM_CTR = 4;
  localparam int CNT_W = 32;
  localparam int NUM_IN = 8;
  localparam int SEL_W = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_PTR_W = 3;
  localparam int SYNC_STAGES = 2;

  // value loaded into the count on arm
  localparam logic [CNT_W-1:0] CNT_INIT = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_STEP = 32'h0000_0001;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT_IDLE = 5'b00010,
    ST_WAIT_ACT = 5'b00100,
    ST_MEAS = 5'b01000,
    ST_HOLD = 5'b10000
  } cepw_st_t;

  typedef enum logic [1:0] {
    DIR_UP = 2'h0,
    DIR_DOWN = 2'h1,
    DIR_EXT = 2'h2
  } cepw_dir_t;

  typedef enum logic {
    MODE_EDGE = 1'b0,
    MODE_PWIDTH = 1'b1
  } cepw_mode_t;

  // per-counter configuration, held steady by software while armed
  typedef struct packed {
    cepw_mode_t mode;
    logic buffered;
    logic sampled;
    logic single_point;
    logic [SEL_W-1:0] src_sel;
    logic [SEL_W-1:0] gate_sel;
    logic [SEL_W-1:0] samp_sel;
    logic [SEL_W-1:0] dir_sel;
    logic src_rise;
    logic samp_rise;
    logic gate_high;
    logic pause_en;
    cepw_dir_t dir_mode;
  } cepw_cfg_t;

  typedef struct packed {
    logic armed;
    logic holding;
    logic overrun;
    logic overflow;
    logic cfg_err;
  } cepw_status_t;

  // one counter's private state, embedded holding counter included
  typedef struct packed {
    logic [NUM_IN-1:0] sync1;
    logic [NUM_IN-1:0] sync2;
    logic [NUM_IN-1:0] prev;
    cepw_st_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] aux_last;
    logic aux_done;
    logic push;
    logic [CNT_W-1:0] push_data;
    cepw_status_t status;
  } cepw_ctr_t;

endpackage : cepw_pkg

//--- verilog/cepw_fifo.sv
// capture fifo with valid/ready on both sides, storage in flip-flops
`timescale 1ns/1ns
module cepw_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int PTR_W = 3
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W:0] wr;
    logic [PTR_W:0] rd;
  } cepw_fifo_state_t;

  cepw_fifo_state_t s;
  cepw_fifo_state_t next_s;
  logic full;
  logic empty;

  assign empty = (s.wr == s.rd);
  assign full = (s.wr[PTR_W-1:0] == s.rd[PTR_W-1:0]) && (s.wr[PTR_W] != s.rd[PTR_W]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = s.mem[s.rd[PTR_W-1:0]];

  always_comb begin
    next_s = s;
    if (in_valid && !full) begin
      next_s.mem[s.wr[PTR_W-1:0]] = in_data;
      next_s.wr = s.wr + {{PTR_W{1'b0}}, 1'b1};
    end
    if (out_ready && !empty) begin
      next_s.rd = s.rd + {{PTR_W{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : cepw_fifo

//--- bench/cepw_far_model.sv
// far-side model: source, gate, sample clock and direction lines of counter 0
`timescale 1ns/1ns
module cepw_far_model (
  input wire logic mclk,
  output logic [7:0] lines
);
  initial lines = 8'h00;
  task automatic set(input int i, input logic v);
    @(posedge mclk);
    #1 lines[i] = v;
  endtask : set
  // each level is held 3 cycles so the 2-flop synchroniser cannot miss it
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      set(i, 1'b1);
      repeat (2) @(posedge mclk);
      set(i, 1'b0);
      repeat (2) @(posedge mclk);
    end
  endtask : pulse
endmodule : cepw_far_model

//--- bench/cepw_checker.sv
// assertions on counter 0 of the edge / pulse-width block
`timescale 1ns/1ns
module cepw_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire cepw_pkg::cepw_cfg_t [3:0] cfg,
  input wire logic [3:0][7:0] sig_in,
  input wire logic [3:0] arm,
  input wire logic [3:0] disarm,
  input wire logic [3:0] dma_ready,
  input wire logic [3:0] dma_valid,
  input wire logic [3:0][31:0] dma_data,
  input wire logic [3:0][31:0] count,
  input wire cepw_pkg::cepw_status_t [3:0] status
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire cepw_pkg::cepw_cfg_t k = cfg[0];
  wire edg = k.mode == cepw_pkg::MODE_EDGE;
  wire bad = edg && k.buffered && !k.sampled && !k.single_point;
  wire arm0 = arm[0] && !disarm[0];
  wire gact = sig_in[0][k.gate_sel] == k.gate_high;
  AST_ARM_ZERO: assert property (arm0 && !bad |=> count[0] == 32'h0 && status[0].armed)
    else $error("arm did not clear the count");
  AST_CFG_ERR: assert property (arm0 && bad |=> status[0].cfg_err && !status[0].armed)
    else $error("unsupported timing was accepted");
  AST_UP: assert property (edg && k.dir_mode == cepw_pkg::DIR_UP && !arm[0]
    ##1 $changed(count[0]) |-> count[0] == $past(count[0]) + 32'h1)
    else $error("up count step wrong");
  AST_DOWN: assert property (edg && k.dir_mode == cepw_pkg::DIR_DOWN && !arm[0]
    ##1 $changed(count[0]) |-> count[0] == $past(count[0]) - 32'h1)
    else $error("down count step wrong");
  AST_PAUSE: assert property ((edg && k.pause_en && gact) [*4] ##0 !arm[0]
    |=> $stable(count[0]))
    else $error("count moved while paused");
  AST_HOLD: assert property (status[0].holding && !arm[0] |=> $stable(count[0]))
    else $error("count moved while holding");
  AST_IDLE: assert property (!status[0].armed && !status[0].holding && !arm[0]
    |=> $stable(count[0]))
    else $error("count moved while idle");
  AST_FIFO: assert property (dma_valid[0] && !dma_ready[0] && !arm[0] && !disarm[0]
    |=> dma_valid[0] && $stable(dma_data[0]))
    else $error("fifo head not held");
  cover property (status[0].holding);
  cover property (status[0].overflow);
  cover property (dma_valid[0] && dma_ready[0]);
endmodule : cepw_checker
bind cepw_top cepw_checker u_chk (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .sig_in(sig_in),
  .arm(arm), .disarm(disarm), .dma_ready(dma_ready), .dma_valid(dma_valid),
  .dma_data(dma_data), .count(count), .status(status));

//--- bench/tb_top.sv
// bench for counter 0: edge counting, pulse width and the capture fifo
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  cepw_pkg::cepw_cfg_t [3:0] cfg = '0;
  cepw_pkg::cepw_cfg_t c;
  logic [7:0] lines;
  logic [3:0] arm = 4'h0;
  logic [3:0] disarm = 4'h0;
  logic [3:0] dma_ready = 4'h0;
  logic [3:0] dma_valid;
  logic [3:0][31:0] dma_data;
  logic [3:0][31:0] count;
  cepw_pkg::cepw_status_t [3:0] status;
  int num_errors = 0;
  int n_compared = 0;
  always #4 mclk = ~mclk;
  cepw_far_model far (.mclk(mclk), .lines(lines));
  // counters 1 to 3 see quiet lines
  cepw_top uut (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .sig_in({24'h000000, lines}),
    .arm(arm), .disarm(disarm), .dma_ready(dma_ready), .dma_valid(dma_valid),
    .dma_data(dma_data), .count(count), .status(status));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic finish_test();
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // lines: 0 source, 1 gate, 2 sample clock, 3 direction; sampling on falling edge
  task automatic base(input logic m, input logic b, input logic s);
    c = '0;
    c.mode = cepw_pkg::cepw_mode_t'(m);
    c.buffered = b;
    c.sampled = s;
    c.gate_sel = 3'h1;
    c.samp_sel = 3'h2;
    c.dir_sel = 3'h3;
    c.src_rise = 1'b1;
    c.gate_high = 1'b1;
  endtask : base
  // config is changed only while disarmed
  task automatic go();
    cyc(1);
    disarm[0] = 1'b1;
    cfg[0] = c;
    cyc(1);
    disarm[0] = 1'b0;
    arm[0] = 1'b1;
    cyc(1);
    arm[0] = 1'b0;
  endtask : go
  task automatic gp(input int n);
    far.set(1, 1'b1);
    cyc(2);
    far.pulse(0, n);
    far.set(1, 1'b0);
    cyc(2);
  endtask : gp
  task automatic pop(input logic [31:0] e);
    int k;
    k = 0;
    while (dma_valid[0] !== 1'b1 && k < 40) begin
      cyc(1);
      k++;
    end
    // a fifo that never offers a word is a failure, not a stale compare
    if (dma_valid[0] !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t: no fifo word within 40 cycles", $time);
    end
    chk(dma_data[0], e);
    dma_ready[0] = 1'b1;
    cyc(1);
    dma_ready[0] = 1'b0;
    cyc(1);
  endtask : pop
  task automatic t_dir();
    base(0, 0, 0);
    go();
    far.pulse(0, 5);
    cyc(4);
    chk(count[0], 32'h5);
    c.dir_mode = cepw_pkg::DIR_DOWN;
    go();
    chk(count[0], 32'h0);
    far.pulse(0, 3);
    cyc(4);
    chk(count[0], 32'hffff_fffd);
    c.dir_mode = cepw_pkg::DIR_EXT;
    go();
    far.set(3, 1'b1);
    far.pulse(0, 4);
    far.set(3, 1'b0);
    cyc(3);
    far.pulse(0, 1);
    cyc(4);
    chk(count[0], 32'h3);
  endtask : t_dir
  task automatic t_pause();
    base(0, 0, 0);
    c.pause_en = 1'b1;
    go();
    far.pulse(0, 2);
    far.set(1, 1'b1);
    cyc(3);
    far.pulse(0, 3);
    far.set(1, 1'b0);
    cyc(3);
    far.pulse(0, 1);
    cyc(4);
    chk(count[0], 32'h3);
  endtask : t_pause
  // sample rises before and falls after each source pulse, so the edge choice shows
  task automatic t_buf();
    base(0, 1, 1);
    go();
    for (int i = 0; i < 9; i++) begin
      far.set(2, 1'b1);
      far.pulse(0, 1);
      far.set(2, 1'b0);
      cyc(2);
    end
    cyc(4);
    chk({31'h0, status[0].overflow}, 32'h1);
    for (int i = 1; i < 9; i++) pop(i);
    chk({31'h0, dma_valid[0]}, 32'h0);
    chk(count[0], 32'h9);
  endtask : t_buf
  task automatic t_cfg();
    base(0, 1, 0);
    go();
    chk({status[0].cfg_err, status[0].armed}, 32'h2);
  endtask : t_cfg
  task automatic t_single();
    base(1, 0, 0);
    far.set(1, 1'b1);
    cyc(3);
    go();
    far.pulse(0, 2);
    far.set(1, 1'b0);
    cyc(3);
    gp(4);
    cyc(4);
    chk({31'h0, status[0].holding}, 32'h1);
    gp(2);
    pop(32'h4);
    cyc(4);
    chk({dma_valid[0], status[0].armed}, 32'h0);
  endtask : t_single
  task automatic t_ipw();
    base(1, 1, 0);
    go();
    gp(2);
    gp(3);
    pop(32'h2);
    pop(32'h3);
  endtask : t_ipw
  task automatic t_spw();
    base(1, 1, 1);
    go();
    gp(2);
    far.pulse(2, 1);
    pop(32'h2);
    chk({31'h0, status[0].overrun}, 32'h0);
    far.pulse(2, 1);
    cyc(4);
    chk({31'h0, status[0].overrun}, 32'h1);
  endtask : t_spw
  initial begin
    cyc(4);
    rst_n = 1'b1;
    cyc(2);
    t_dir();
    t_pause();
    t_buf();
    t_cfg();
    t_single();
    t_ipw();
    t_spw();
    finish_test();
  end
  // ample margin over the roughly 450 cycles the tests take
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule : tb_top
